// ### rtl/pci_bridge_dr_cfg_target.sv
// Delayed read engine and local configuration target of the bridge
`timescale 1ns/1ns
`default_nettype none

// Read data buffer between the target-side master and the initiator side
module rd_data_fifo
	import pci_dr_pkg::*;
#(
	parameter int WIDTH = RD_FIFO_WIDTH,
	parameter int DEPTH = RD_FIFO_DEPTH
)(
	input  wire logic                     clk,       // Clock
	input  wire logic                     rst,       // Async reset
	input  wire logic                     flush,     // Drop all words
	input  wire logic                     in_valid,  // Write request
	output logic                          in_ready,  // Room left
	input  wire logic [WIDTH-1:0]         in_data,   // Write word
	output logic                          out_valid, // Word present
	input  wire logic                     out_ready, // Read request
	output logic [WIDTH-1:0]              out_data,  // Head word
	output logic [$clog2(DEPTH+1)-1:0]    level      // Words held
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [CW-1:0]    cnt_q;
	logic             do_wr;
	logic             do_rd;

	assign in_ready  = cnt_q != CW'(DEPTH);
	assign out_valid = cnt_q != '0;
	assign out_data  = mem[rd_q];
	assign level     = cnt_q;
	assign do_wr     = in_valid && in_ready && !flush;
	assign do_rd     = out_ready && out_valid && !flush;

	// Storage has no reset; only the pointers and the count matter
	always_ff @(posedge clk)
		if (do_wr)
			mem[wr_q] <= in_data;

	// Pointers wrap explicitly so any depth works
	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end
		else if (flush)
		begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (do_wr)
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			if (do_rd)
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			cnt_q <= cnt_q + CW'(do_wr) - CW'(do_rd);
		end
endmodule : rd_data_fifo

module pci_bridge_dr_cfg_target
	import pci_dr_pkg::*;
#(
	parameter int FIFO_DEPTH    = RD_FIFO_DEPTH,
	parameter int RETRY_MAX     = RETRY_LIMIT,
	parameter int DISCARD_LONG_CLKS  = DISCARD_LONG,
	parameter int DISCARD_SHORT_CLKS = DISCARD_SHORT
)(
	input  wire logic        mclk,                   // Bus clock
	input  wire logic        sys_rst,                // Async reset
	input  wire logic        p_frame_n,              // Primary FRAME
	input  wire logic        p_irdy_n,               // Primary IRDY
	input  wire logic [31:0] p_ad_in,                // Primary AD in
	input  wire logic [3:0]  p_cbe_n,                // Primary C/BE
	input  wire logic        p_par_in,               // Primary PAR
	input  wire logic        primary_config_select,  // Config select
	output logic [31:0]      p_ad_out,               // Primary AD out
	output logic             p_ad_oe,                // AD enable
	output logic             primary_device_select_out_n, // DEVSEL
	output logic             p_trdy_n_out,           // TRDY
	output logic             p_stop_n_out,           // STOP
	output logic             p_tgt_oe,               // Target ctl enable
	output logic             primary_system_error_out_n, // SERR level
	output logic             primary_system_error_oe, // SERR enable
	input  wire logic        serr_enable,            // SERR allowed
	input  wire logic        master_timeout_sel,     // Short discard
	input  wire logic        posted_writes_empty,    // Ordering met
	input  wire logic        mem_read_prefetchable,  // Address decode
	output logic             s_req_n,                // Secondary REQ
	input  wire logic        s_gnt_n,                // Secondary GNT
	output logic             s_frame_n_out,          // FRAME
	output logic             s_irdy_n_out,           // IRDY
	output logic             s_mst_oe,               // Master ctl enable
	output logic [31:0]      s_ad_out,               // Secondary AD out
	output logic             s_ad_oe,                // AD enable
	input  wire logic [31:0] s_ad_in,                // Secondary AD in
	output logic [3:0]       s_cbe_n_out,            // C/BE out
	output logic             s_par_out,              // Address parity
	input  wire logic        s_devsel_n,             // DEVSEL in
	input  wire logic        s_trdy_n,               // TRDY in
	input  wire logic        s_stop_n,               // STOP in
	output cfg_acc_t         cfg_req,                // Config access
	output logic             cfg_wr,                 // Config write pulse
	output logic             cfg_rd,                 // Config read pulse
	input  wire logic [31:0] cfg_rdata               // Config read data
);
	localparam int LW = $clog2(FIFO_DEPTH + 1);

	tgt_state_t tgt_q;
	mst_state_t mst_q;
	dr_req_t    q [DRQ_DEPTH];
	dr_req_t    cur_q;
	dr_req_t    push_rec;
	logic [1:0] q_cnt_q;
	logic       frame_prev_q, abandon_q, head_done_q, head_abort_q;
	logic       got_q, serr_q;
	logic [RETRY_CNT_W-1:0]   retry_q;
	logic [DISCARD_CNT_W-1:0] disc_q;
	logic [2:0]  dsel_cnt_q;
	logic [31:0] s_addr_q;
	logic        addr_phase, cfg_hit, dread, hit_any, hit_head, deliver;
	logic        q_push, q_pop, pop_abort, pop_tgt, pop_mst, pop_disc;
	logic        x_done, x_slot, x_end, x_drain, x_last;
	logic        m_trdy, m_stop, m_mabort, m_end, m_retry_abort, disc_run;
	logic        f_in_ready, f_out_valid, f_pop, f_push;
	logic [31:0] f_out;
	logic [LW-1:0] f_level;

	rd_data_fifo #(.WIDTH(RD_FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk       (mclk),
		.rst       (sys_rst),
		.flush     (q_pop),
		.in_valid  (f_push),
		.in_ready  (f_in_ready),
		.in_data   (s_ad_in),
		.out_valid (f_out_valid),
		.out_ready (f_pop),
		.out_data  (f_out),
		.level     (f_level)
	);

	// Address phase decode on the primary bus
	assign addr_phase = !p_frame_n && frame_prev_q && p_irdy_n;
	assign cfg_hit = (p_cbe_n == CMD_CFG_RD || p_cbe_n == CMD_CFG_WR)
		&& p_ad_in[1:0] == CFG_TYPE0 && primary_config_select;
	assign dread = is_mem_rd(p_cbe_n) || p_cbe_n == CMD_IO_RD
		|| (p_cbe_n == CMD_CFG_RD && p_ad_in[1:0] == CFG_TYPE1);

	// Look for the repeated read among queued entries
	always_comb
	begin
		hit_any  = 1'b0;
		hit_head = 1'b0;
		for (int i = 0; i < DRQ_DEPTH; i++)
			if (2'(i) < q_cnt_q && q[i].addr == p_ad_in
				&& cmd_alias(q[i].cmd, p_cbe_n))
			begin
				hit_any = 1'b1;
				if (i == 0)
					hit_head = 1'b1;
			end
	end

	// Flow-through only for prefetchable data while the target read runs
	assign deliver = posted_writes_empty && !head_abort_q
		&& (head_done_q || (q[0].pref && mst_q == M_DATA
		&& !abandon_q && f_out_valid));

	// Delivery phase bookkeeping
	assign x_done  = !p_trdy_n_out && !p_irdy_n;
	assign x_slot  = tgt_q == T_XFER && (p_trdy_n_out || x_done);
	assign x_end   = x_done && (!p_stop_n_out || p_frame_n);
	assign x_drain = x_slot && !x_end && !f_out_valid && head_done_q;
	assign x_last  = !q[0].pref || (head_done_q && f_level == LW'(1));
	assign f_pop   = x_slot && !x_end && f_out_valid;

	// Queue updates; any pop also flushes the buffer of the old head
	assign q_push    = tgt_q == T_CAPT && !p_irdy_n;
	assign pop_abort = tgt_q == T_IDLE && addr_phase && !cfg_hit && dread
		&& hit_head && head_abort_q;
	assign pop_tgt   = (x_slot && x_end && head_done_q) || x_drain;
	assign q_pop     = pop_abort || pop_tgt || pop_mst || pop_disc;

	always_comb
	begin
		push_rec      = cur_q;
		push_rec.be_n = p_cbe_n;
	end

	always_ff @(posedge mclk or posedge sys_rst)
		if (sys_rst)
			frame_prev_q <= 1'b1;
		else
			frame_prev_q <= p_frame_n;

	// Delayed transaction queue, head at index zero
	always_ff @(posedge mclk or posedge sys_rst)
		if (sys_rst)
		begin
			q_cnt_q <= '0;
			for (int i = 0; i < DRQ_DEPTH; i++)
				q[i] <= '0;
		end
		else
		begin
			if (q_pop)
				for (int i = 0; i < DRQ_DEPTH - 1; i++)
					q[i] <= q[i + 1];
			if (q_push)
				q[q_pop ? q_cnt_q - 2'd1 : q_cnt_q] <= push_rec;
			q_cnt_q <= q_cnt_q + 2'(q_push) - 2'(q_pop);
		end

	// Initiator stopping before the target read ends abandons the head
	always_ff @(posedge mclk or posedge sys_rst)
		if (sys_rst)
			abandon_q <= 1'b0;
		else if (q_pop)
			abandon_q <= 1'b0;
		else if (x_slot && x_end && !head_done_q)
			abandon_q <= 1'b1;

	// Primary target: retry, delivery, target abort, config access
	always_ff @(posedge mclk or posedge sys_rst)
		if (sys_rst)
		begin
			tgt_q <= T_IDLE;
			cur_q <= '0;
			p_tgt_oe <= 1'b0;
			primary_device_select_out_n <= 1'b1;
			p_trdy_n_out <= 1'b1;
			p_stop_n_out <= 1'b1;
			p_ad_out <= '0;
			p_ad_oe <= 1'b0;
			cfg_req <= '0;
			cfg_wr <= 1'b0;
			cfg_rd <= 1'b0;
		end
		else
		begin
			cfg_wr <= 1'b0;
			cfg_rd <= 1'b0;
			unique case (tgt_q)
			T_IDLE:
			begin
				p_tgt_oe <= 1'b0;
				p_ad_oe  <= 1'b0;
				if (addr_phase)
				begin
					cur_q.addr <= p_ad_in;
					cur_q.cmd  <= p_cbe_n;
					cur_q.par  <= p_par_in;
					cur_q.pref <= p_cbe_n == CMD_MRL || p_cbe_n == CMD_MRM
						|| (p_cbe_n == CMD_MEM_RD && mem_read_prefetchable);
					if (cfg_hit)
					begin
						tgt_q    <= T_CFG;
						p_tgt_oe <= 1'b1;
						primary_device_select_out_n <= 1'b0;
						cfg_rd <= p_cbe_n == CMD_CFG_RD;
						cfg_req.reg_num <= p_ad_in[CFG_REG_MSB:CFG_REG_LSB];
					end
					else if (dread)
					begin
						p_tgt_oe <= 1'b1;
						if (hit_head && head_abort_q)
						begin
							tgt_q <= T_ABORT;
							p_stop_n_out <= 1'b0;
						end
						else if (hit_head && deliver)
						begin
							tgt_q <= T_XFER;
							primary_device_select_out_n <= 1'b0;
						end
						else if (hit_any || q_cnt_q == 2'(DRQ_DEPTH))
						begin
							tgt_q <= T_HOLD;
							primary_device_select_out_n <= 1'b0;
							p_stop_n_out <= 1'b0;
						end
						else
						begin
							tgt_q <= T_CAPT;
							primary_device_select_out_n <= 1'b0;
						end
					end
				end
			end
			T_CAPT:
				if (!p_irdy_n)
				begin
					tgt_q <= T_HOLD;
					p_stop_n_out <= 1'b0;
				end
			T_HOLD, T_ABORT:
				if (p_frame_n)
				begin
					tgt_q <= T_TURN;
					primary_device_select_out_n <= 1'b1;
					p_trdy_n_out <= 1'b1;
					p_stop_n_out <= 1'b1;
					p_ad_oe <= 1'b0;
				end
			T_TURN:
			begin
				tgt_q    <= T_IDLE;
				p_tgt_oe <= 1'b0;
			end
			T_CFG:
				if (!p_irdy_n)
				begin
					tgt_q <= T_CFGD;
					p_trdy_n_out <= 1'b0;
					p_stop_n_out <= p_frame_n;
					p_ad_out <= cfg_rdata;
					p_ad_oe  <= cur_q.cmd == CMD_CFG_RD;
				end
			T_CFGD:
			begin
				cfg_wr <= cur_q.cmd == CMD_CFG_WR;
				cfg_req.be_n  <= p_cbe_n;
				cfg_req.wdata <= p_ad_in;
				p_trdy_n_out <= 1'b1;
				p_ad_oe <= 1'b0;
				if (p_frame_n)
				begin
					tgt_q <= T_TURN;
					primary_device_select_out_n <= 1'b1;
					p_stop_n_out <= 1'b1;
				end
				else
					tgt_q <= T_HOLD;
			end
			T_XFER:
				if (x_slot && x_end)
				begin
					p_trdy_n_out <= 1'b1;
					if (p_frame_n)
					begin
						tgt_q <= T_TURN;
						primary_device_select_out_n <= 1'b1;
						p_stop_n_out <= 1'b1;
						p_ad_oe <= 1'b0;
					end
					else
						tgt_q <= T_HOLD;
				end
				else if (f_pop)
				begin
					p_trdy_n_out <= 1'b0;
					p_ad_out <= f_out;
					p_ad_oe  <= 1'b1;
					p_stop_n_out <= !x_last;
				end
				else if (x_drain)
				begin
					tgt_q <= T_HOLD;
					p_trdy_n_out <= 1'b1;
					p_stop_n_out <= 1'b0;
				end
				else if (x_slot)
					p_trdy_n_out <= 1'b1;
			endcase
		end

	// Target bus phase decode for the secondary master
	assign m_trdy   = !s_trdy_n && !s_devsel_n;
	assign m_stop   = !s_stop_n && !s_devsel_n;
	assign m_mabort = dsel_cnt_q == DEVSEL_WAIT && s_devsel_n && !got_q;
	assign m_end    = mst_q == M_DATA && (m_mabort
		|| (s_frame_n_out && (m_trdy || m_stop)));
	assign f_push   = mst_q == M_DATA && m_trdy && !abandon_q;
	assign pop_mst  = m_end && abandon_q;
	assign m_retry_abort = m_end && !m_mabort && !got_q && !m_trdy
		&& retry_q == RETRY_CNT_W'(RETRY_MAX - 1);

	// Secondary master: issue head read, retry, burst, terminate
	always_ff @(posedge mclk or posedge sys_rst)
		if (sys_rst)
		begin
			mst_q <= M_IDLE;
			s_req_n <= 1'b1;
			s_frame_n_out <= 1'b1;
			s_irdy_n_out <= 1'b1;
			s_mst_oe <= 1'b0;
			s_ad_out <= '0;
			s_ad_oe <= 1'b0;
			s_cbe_n_out <= '0;
			s_par_out <= 1'b0;
			s_addr_q <= '0;
			got_q <= 1'b0;
			dsel_cnt_q <= '0;
			head_done_q <= 1'b0;
			head_abort_q <= 1'b0;
			retry_q <= '0;
		end
		else
		begin
			if (q_pop || (q_push && q_cnt_q == '0))
			begin
				head_done_q  <= 1'b0;
				head_abort_q <= 1'b0;
				retry_q <= '0;
			end
			unique case (mst_q)
			M_IDLE:
				if (q_cnt_q != '0 && !head_done_q && !head_abort_q
					&& !q_pop && posted_writes_empty && f_in_ready)
				begin
					mst_q <= M_REQ;
					s_req_n <= 1'b0;
				end
			M_REQ:
				if (!s_gnt_n)
				begin
					mst_q <= M_ADDR;
					s_req_n <= 1'b1;
					s_mst_oe <= 1'b1;
					s_frame_n_out <= 1'b0;
					s_ad_out <= q[0].addr;
					s_ad_oe <= 1'b1;
					s_cbe_n_out <= q[0].cmd;
					s_par_out <= q[0].par;
					s_addr_q <= q[0].addr;
					got_q <= 1'b0;
					dsel_cnt_q <= '0;
				end
			M_ADDR:
			begin
				mst_q <= M_DATA;
				s_irdy_n_out <= 1'b0;
				s_ad_oe <= 1'b0;
				s_cbe_n_out <= q[0].be_n;
				s_frame_n_out <= !q[0].pref
					|| s_addr_q[11:2] == DW_LAST_4K;
			end
			M_DATA:
			begin
				if (dsel_cnt_q != DEVSEL_WAIT)
					dsel_cnt_q <= dsel_cnt_q + 3'd1;
				if (m_trdy)
				begin
					got_q <= 1'b1;
					s_addr_q <= s_addr_q + 32'd4;
					s_cbe_n_out <= BE_ALL_N;
				end
				if (m_end)
				begin
					mst_q <= M_TURN;
					s_frame_n_out <= 1'b1;
					s_irdy_n_out <= 1'b1;
					if (!abandon_q)
					begin
						if (got_q || m_trdy)
							head_done_q <= 1'b1;
						else if (m_mabort || m_retry_abort)
							head_abort_q <= 1'b1;
						else
							retry_q <= retry_q + 1'b1;
					end
				end
				else if (!s_frame_n_out && (m_stop || abandon_q
					|| (m_trdy && (s_addr_q[11:2] == DW_BEFORE_4K
					|| f_level >= LW'(FIFO_DEPTH - 3)))))
					s_frame_n_out <= 1'b1;
			end
			M_TURN:
			begin
				s_mst_oe <= 1'b0;
				mst_q <= (head_done_q || head_abort_q || q_cnt_q == '0)
					? M_IDLE : M_REQ;
				s_req_n <= head_done_q || head_abort_q || q_cnt_q == '0;
			end
			endcase
		end

	// Discard timer on a completed head whose data waits
	assign disc_run = q_cnt_q != '0 && head_done_q && f_out_valid
		&& tgt_q == T_IDLE;
	assign pop_disc = disc_run && disc_q == DISCARD_CNT_W'(1);

	always_ff @(posedge mclk or posedge sys_rst)
		if (sys_rst)
			disc_q <= DISCARD_CNT_W'(DISCARD_LONG);
		else if (!disc_run)
			disc_q <= master_timeout_sel
				? DISCARD_CNT_W'(DISCARD_SHORT_CLKS)
				: DISCARD_CNT_W'(DISCARD_LONG_CLKS);
		else
			disc_q <= disc_q - 1'b1;

	// System error is a one-clock pulse, gated by its enable
	always_ff @(posedge mclk or posedge sys_rst)
		if (sys_rst)
			serr_q <= 1'b0;
		else
			serr_q <= serr_enable && (m_retry_abort || pop_disc);

	assign primary_system_error_out_n = 1'b0;
	assign primary_system_error_oe    = serr_q;

endmodule : pci_bridge_dr_cfg_target
`default_nettype wire

// ### rtl/pci_dr_pkg.sv
// Shared constants, records and state codes for the delayed read bridge
package pci_dr_pkg;

	// Bus commands
	localparam logic [3:0] CMD_IO_RD  = 4'h2;
	localparam logic [3:0] CMD_MEM_RD = 4'h6;
	localparam logic [3:0] CMD_CFG_RD = 4'hA;
	localparam logic [3:0] CMD_CFG_WR = 4'hB;
	localparam logic [3:0] CMD_MRM    = 4'hC;
	localparam logic [3:0] CMD_MRL    = 4'hE;

	// Configuration address layout
	localparam logic [1:0] CFG_TYPE0   = 2'h0;
	localparam logic [1:0] CFG_TYPE1   = 2'h1;
	localparam int         CFG_REG_LSB = 2;
	localparam int         CFG_REG_MSB = 7;
	localparam int         CFG_FN_LSB  = 8;
	localparam int         CFG_FN_MSB  = 10;
	localparam int         CFG_DEV_LSB = 11;
	localparam int         CFG_DEV_MSB = 15;
	localparam int         CFG_BUS_LSB = 16;
	localparam int         CFG_BUS_MSB = 23;

	// Sizes, limits and counts
	localparam int          DRQ_DEPTH       = 3;
	localparam int          RD_FIFO_DEPTH   = 32;
	localparam int          RD_FIFO_WIDTH   = 32;
	localparam int          RETRY_LIMIT     = 16777216;
	localparam int          RETRY_CNT_W     = 25;
	localparam int          DISCARD_LONG    = 32768;
	localparam int          DISCARD_SHORT   = 1024;
	localparam int          DISCARD_CNT_W   = 16;
	localparam logic [2:0]  DEVSEL_WAIT     = 3'h5;
	localparam logic [9:0]  DW_BEFORE_4K    = 10'h3fe;
	localparam logic [9:0]  DW_LAST_4K      = 10'h3ff;
	localparam logic [3:0]  BE_ALL_N        = 4'h0;

	// One queued delayed read
	typedef struct packed {
		logic [31:0] addr;
		logic [3:0]  cmd;
		logic        par;
		logic [3:0]  be_n;
		logic        pref;
	} dr_req_t;

	// One access to the local configuration space
	typedef struct packed {
		logic [5:0]  reg_num;
		logic [3:0]  be_n;
		logic [31:0] wdata;
	} cfg_acc_t;

	typedef enum logic [7:0] {
		T_IDLE  = 8'h01,
		T_CAPT  = 8'h02,
		T_HOLD  = 8'h04,
		T_TURN  = 8'h08,
		T_ABORT = 8'h10,
		T_CFG   = 8'h20,
		T_CFGD  = 8'h40,
		T_XFER  = 8'h80
	} tgt_state_t;

	typedef enum logic [4:0] {
		M_IDLE = 5'h01,
		M_REQ  = 5'h02,
		M_ADDR = 5'h04,
		M_DATA = 5'h08,
		M_TURN = 5'h10
	} mst_state_t;

	function automatic logic is_mem_rd(input logic [3:0] c);
		return c == CMD_MEM_RD || c == CMD_MRL || c == CMD_MRM;
	endfunction : is_mem_rd

	function automatic logic cmd_alias(input logic [3:0] a, input logic [3:0] b);
		return a == b || (is_mem_rd(a) && is_mem_rd(b));
	endfunction : cmd_alias

endpackage : pci_dr_pkg

// ### test/pci_bridge_dr_cfg_target_tb.sv
// Self-checking bench for the delayed read bridge
`timescale 1ns/1ns
`default_nettype none
module pci_bridge_dr_cfg_target_tb;
	import pci_dr_pkg::*;
	logic		mclk, sys_rst, p_frame_n, p_irdy_n, p_par_in;
	logic		primary_config_select, serr_enable, master_timeout_sel;
	logic		posted_writes_empty, mem_read_prefetchable;
	logic [31:0]	p_ad_in, p_ad_out, s_ad_out, s_ad_in, cfg_rdata;
	logic [3:0]	p_cbe_n, s_cbe_n_out, last_be, be;
	logic		primary_device_select_out_n, p_trdy_n_out, p_stop_n_out;
	logic		p_tgt_oe, primary_system_error_oe, s_req_n, s_gnt_n;
	logic		s_frame_n_out, s_irdy_n_out, s_mst_oe, s_devsel_n;
	logic		s_trdy_n, s_stop_n, cfg_wr, cfg_rd;
	logic [7:0]	retries, slow;
	logic		p_ad_oe, s_ad_oe, s_par_out, primary_system_error_out_n;
	cfg_acc_t	cfg_req, wseen;
	logic [31:0]	dat [0:7];
	int		got, rsp, k, cyc, serr_cnt, mismatches, n_checks;
	// Short limits keep the run brief
	pci_bridge_dr_cfg_target #(.RETRY_MAX(4), .DISCARD_LONG_CLKS(40),
		.DISCARD_SHORT_CLKS(20)) uut (.*);
	sec_target_model partner (.clk(mclk), .rst(sys_rst), .req_n(s_req_n),
		.gnt_n(s_gnt_n), .frame_n(s_frame_n_out), .irdy_n(s_irdy_n_out),
		.oe(s_mst_oe), .ad(s_ad_out), .cbe_n(s_cbe_n_out), .retries, .slow,
		.ad_in(s_ad_in), .devsel_n(s_devsel_n), .trdy_n(s_trdy_n),
		.stop_n(s_stop_n), .last_be);
	// Clock
	initial
	begin
		mclk = 1'h0;
		forever #25 mclk = ~mclk;
	end
	// Config writes, error pulses, timeout
	always @(posedge mclk)
	begin
		cyc++;
		if (cfg_wr)
			wseen = cfg_req;
		if (primary_system_error_oe)
			serr_cnt++;
		if (cyc == 20000)
		begin
			mismatches++;
			finish_test();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask : tick
	task automatic chk(input string nm, input logic [63:0] e, s);
		n_checks++;
		if (s !== e)
		begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// Primary initiator: up to n phases; rsp 1 data, 2 retry, 3 abort
	task automatic pri(input logic [31:0] a, input logic [3:0] c,
		input int n, input logic [31:0] wd);
		got = 0;
		rsp = 0;
		p_frame_n = 1'h0;
		p_ad_in = a;
		p_cbe_n = c;
		tick(1);
		p_irdy_n = 1'h0;
		p_cbe_n = be;
		p_ad_in = wd;
		p_frame_n = n == 1;
		for (int i = 0; i < 20 && rsp == 0; i++)
		begin
			@(posedge mclk);
			if (!p_trdy_n_out && p_tgt_oe)
			begin
				dat[got] = p_ad_out;
				got++;
			end
			if (!p_stop_n_out && p_tgt_oe)
				rsp = primary_device_select_out_n ? 3 : got ? 1 : 2;
			else if (got == n)
				rsp = 1;
			#2;
			if (got == n - 1)
				p_frame_n = 1'h1;
		end
		if (!p_frame_n)
		begin
			p_frame_n = 1'h1;
			tick(1);
		end
		p_irdy_n = 1'h1;
		tick(3);
	endtask : pri
	// Repeat while retried
	task automatic rd_until(input logic [31:0] a, input logic [3:0] c,
		input int n);
		for (int t = 0; t < 60; t++)
		begin
			pri(a, c, n, 0);
			if (rsp != 2)
				break;
			tick(4);
		end
	endtask : rd_until
	// Own config space
	task automatic t_cfg;
		be = 4'h5;
		pri(32'h0000_0710, CMD_CFG_RD, 2, 0);
		chk("cfg rd words", 1, got);
		chk("cfg rd data", cfg_rdata, dat[0]);
		be = 4'h3;
		pri(32'h0000_0524, CMD_CFG_WR, 1, 32'h1234_5678);
		chk("cfg wr", {6'h09, 4'h3, 32'h1234_5678}, wseen);
		primary_config_select = 1'h0;
		pri(32'h0000_0008, CMD_CFG_RD, 1, 0);
		chk("cfg unselected", 0, rsp);
		$display("test cfg done");
	endtask : t_cfg
	// Non-prefetchable read
	task automatic t_np;
		be = 4'h5;
		retries = 8'h02;
		pri(32'h0000_2000, CMD_MEM_RD, 1, 0);
		chk("np queued", 2, rsp);
		rd_until(32'h0000_2000, CMD_MEM_RD, 4);
		chk("np words", 1, got);
		chk("np data", 32'h0000_2000, dat[0]);
		chk("np be", 4'h5, last_be);
		chk("np idle", 1, s_req_n);
		$display("test np done");
	endtask : t_np
	// Prefetch burst, alias, early stop
	task automatic t_pf;
		be = 4'h0;
		slow = 8'h03;
		mem_read_prefetchable = 1'h1;
		pri(32'h0000_3000, CMD_MRL, 1, 0);
		rd_until(32'h0000_3000, CMD_MRM, 4);
		chk("pf words", 4, got);
		for (k = 0; k < 4; k++)
			chk("pf data", 32'h0000_3000 + 4 * k, dat[k]);
		pri(32'h0000_4000, CMD_MRL, 1, 0);
		rd_until(32'h0000_4000, CMD_MEM_RD, 2);
		chk("pf fresh", 32'h0000_4000, dat[0]);
		slow = 8'h00;
		$display("test pf done");
	endtask : t_pf
	// Endless retry gives abort
	task automatic t_abort;
		retries = 8'hff;
		serr_enable = 1'h1;
		serr_cnt = 0;
		rd_until(32'h0000_5000, CMD_IO_RD, 1);
		chk("abort rsp", 3, rsp);
		chk("abort error", 1, serr_cnt);
		retries = 8'h00;
		pri(32'h0000_5000, CMD_IO_RD, 1, 0);
		chk("abort requeued", 2, rsp);
		rd_until(32'h0000_5000, CMD_IO_RD, 1);
		chk("abort fresh", 1, rsp);
		$display("test abort done");
	endtask : t_abort
	// Discard timer, then write ordering
	task automatic t_disc;
		master_timeout_sel = 1'h1;
		serr_cnt = 0;
		pri(32'h0000_6000, CMD_MEM_RD, 1, 0);
		tick(60);
		chk("disc error", 1, serr_cnt);
		pri(32'h0000_6000, CMD_MEM_RD, 1, 0);
		chk("disc requeued", 2, rsp);
		rd_until(32'h0000_6000, CMD_MEM_RD, 1);
		master_timeout_sel = 1'h0;
		pri(32'h0000_7000, CMD_MEM_RD, 1, 0);
		tick(34);
		pri(32'h0000_7000, CMD_MEM_RD, 1, 0);
		chk("disc long", 32'h0000_7000, dat[0]);
		posted_writes_empty = 1'h0;
		pri(32'h0000_8000, CMD_MEM_RD, 1, 0);
		tick(30);
		chk("order hold", 1, s_req_n);
		posted_writes_empty = 1'h1;
		rd_until(32'h0000_8000, CMD_MEM_RD, 1);
		chk("order data", 32'h0000_8000, dat[0]);
		$display("test disc done");
	endtask : t_disc
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test
	// Reset, then scenarios
	initial
	begin
		{sys_rst, p_frame_n, p_irdy_n, p_par_in} = 4'hf;
		{primary_config_select, posted_writes_empty} = 2'h3;
		{serr_enable, master_timeout_sel, mem_read_prefetchable} = 3'h0;
		{p_ad_in, p_cbe_n, be} = 40'h0;
		{retries, slow, cyc, mismatches, n_checks, serr_cnt} = 0;
		cfg_rdata = 32'hc0ff_ee01;
		tick(12);
		sys_rst = 1'h0;
		tick(2);
		t_cfg();
		t_np();
		t_pf();
		t_abort();
		t_disc();
		finish_test();
	end
endmodule : pci_bridge_dr_cfg_target_tb
`default_nettype wire

// ### test/pci_dr_chk_asserts.sv
// Port-level protocol checks for the delayed read bridge
`timescale 1ns/1ns
`default_nettype none
module pci_dr_chk
	import pci_dr_pkg::*;
(
	input wire logic	mclk,	// Clock
	input wire logic	sys_rst,	// Reset
	input wire logic	p_frame_n,	// FRAME
	input wire logic [31:0]	p_ad_in,	// AD
	input wire logic [3:0]	p_cbe_n,	// C/BE
	input wire logic	primary_config_select,	// Select
	input wire logic	primary_device_select_out_n,	// DEVSEL
	input wire logic	p_tgt_oe,	// Enable
	input wire logic	primary_system_error_oe,	// SERR
	input wire logic	serr_enable,	// SERR on
	input wire logic	posted_writes_empty,	// Order
	input wire logic	s_req_n,	// REQ
	input wire logic	s_gnt_n,	// GNT
	input wire logic	s_frame_n_out,	// FRAME
	input wire logic	s_irdy_n_out,	// IRDY
	input wire logic	s_mst_oe,	// Enable
	input wire logic [3:0]	s_cbe_n_out,	// C/BE
	input wire logic	s_devsel_n,	// DEVSEL
	input wire logic	s_trdy_n,	// TRDY
	input wire logic	cfg_rd	// Read pulse
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	logic	fr_q, adr, cfg, xfer;
	// Last FRAME level, to find the address phase
	always_ff @(posedge mclk or posedge sys_rst)
		if (sys_rst)
			fr_q <= 1'h1;
		else
			fr_q <= p_frame_n;
	// Address phase and transfer decodes
	assign adr = fr_q && !p_frame_n && !p_tgt_oe;
	assign cfg = adr && p_ad_in[1:0] == CFG_TYPE0
		&& p_cbe_n[3:1] == CMD_CFG_RD[3:1];
	assign xfer = s_mst_oe && !s_irdy_n_out && !s_devsel_n && !s_trdy_n;
	a_read_answer: assert property (adr && p_cbe_n == CMD_MEM_RD |=> p_tgt_oe)
		else $error("read not answered");
	a_cfg_claim: assert property (cfg && primary_config_select
		|=> !primary_device_select_out_n)
		else $error("own config not claimed");
	a_cfg_unsel: assert property (cfg && !primary_config_select
		|=> primary_device_select_out_n)
		else $error("config claimed without select");
	a_cfg_read: assert property (cfg && primary_config_select
		&& p_cbe_n == CMD_CFG_RD |=> cfg_rd ##1 !cfg_rd)
		else $error("config read pulse wrong");
	a_serr_pulse: assert property (primary_system_error_oe
		|-> serr_enable ##1 !primary_system_error_oe)
		else $error("error pulse wrong");
	a_req_order: assert property ($fell(s_req_n) |-> $past(posted_writes_empty))
		else $error("request before writes drained");
	a_grant_addr: assert property (!s_gnt_n && !s_req_n && !s_mst_oe
		|=> s_mst_oe && !s_frame_n_out)
		else $error("grant not used");
	a_no_wait: assert property (s_mst_oe && !s_frame_n_out && !s_irdy_n_out
		|=> !s_irdy_n_out)
		else $error("master wait state");
	a_burst_be: assert property (xfer && !s_frame_n_out
		|=> s_cbe_n_out == BE_ALL_N)
		else $error("later enables not zero");
	c_cfg_rd: cover property (cfg_rd);
	c_serr: cover property (primary_system_error_oe);
	c_burst: cover property (xfer && !s_frame_n_out);
endmodule : pci_dr_chk
bind pci_bridge_dr_cfg_target pci_dr_chk u_chk (.*);
`default_nettype wire

// ### test/sec_target_model.sv
// Secondary bus target and arbiter answering the bridge
`timescale 1ns/1ns
`default_nettype none
module sec_target_model
(
	input wire logic	clk,	// Clock
	input wire logic	rst,	// Reset
	input wire logic	req_n,	// Request
	output logic	gnt_n,	// Grant
	input wire logic	frame_n,	// FRAME
	input wire logic	irdy_n,	// IRDY
	input wire logic	oe,	// Master drives
	input wire logic [31:0]	ad,	// Address
	input wire logic [3:0]	cbe_n,	// C/BE
	input wire logic [7:0]	retries,	// Retries per read
	input wire logic [7:0]	slow,	// Waits before data
	output logic [31:0]	ad_in,	// Data, word = address
	output logic	devsel_n,	// DEVSEL
	output logic	trdy_n,	// TRDY
	output logic	stop_n,	// STOP
	output logic [3:0]	last_be	// C/BE at last transfer
);
	logic		act_q, fr_q;
	logic [31:0]	a_q;
	logic [7:0]	n_q, w_q;
	// Released AD shows the inverse so stale data cannot pass
	assign ad_in = trdy_n ? ~a_q : a_q;
	// Grant on idle bus only; retry, wait, then stream words
	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			gnt_n <= 1'h1;
			act_q <= 1'h0;
			fr_q <= 1'h1;
			a_q <= 32'h0000_0000;
			n_q <= 8'h00;
			w_q <= 8'h00;
			devsel_n <= 1'h1;
			trdy_n <= 1'h1;
			stop_n <= 1'h1;
			last_be <= 4'hf;
		end
		else
		begin
			fr_q <= frame_n;
			gnt_n <= req_n | oe | act_q;
			if (!act_q && oe && !frame_n && fr_q)
			begin
				act_q <= 1'h1;
				a_q <= ad;
				w_q <= slow;
				devsel_n <= 1'h0;
				stop_n <= !(n_q < retries);
			end
			else if (act_q && !stop_n && frame_n)
			begin
				act_q <= 1'h0;
				devsel_n <= 1'h1;
				stop_n <= 1'h1;
				n_q <= n_q + 8'h01;
			end
			else if (act_q && stop_n && !trdy_n && !irdy_n)
			begin
				a_q <= a_q + 32'h0000_0004;
				last_be <= cbe_n;
				n_q <= 8'h00;
				act_q <= !frame_n;
				devsel_n <= frame_n;
				trdy_n <= frame_n;
			end
			else if (act_q && stop_n && w_q != 8'h00)
				w_q <= w_q - 8'h01;
			else if (act_q && stop_n)
				trdy_n <= 1'h0;
		end
endmodule : sec_target_model
`default_nettype wire
